/* logic/irq_flags_pkg.sv */
// Package: register map, field positions and reset values of the request-flag block
package irq_flags_pkg;

  // Register byte offsets (AXI4-Lite word aligned)
  localparam logic [7:0] OFF_FLAGS_ONE   = 8'h00;
  localparam logic [7:0] OFF_FLAGS_TWO   = 8'h04;
  localparam logic [7:0] OFF_ENABLE_ONE  = 8'h08;
  localparam logic [7:0] OFF_ENABLE_TWO  = 8'h0c;
  localparam logic [7:0] OFF_POWER_CTRL  = 8'h10;
  localparam logic [7:0] OFF_CORE_CTRL   = 8'h14;

  // First flag register fields
  localparam int BIT_TIMER_ONE_COUNT_OVF  = 0;
  localparam int BIT_TMR2_MAT  = 1;
  localparam int BIT_CAPCMP1   = 2;
  localparam int BIT_SERIAL    = 3;

  // Second flag register fields
  localparam int BIT_CAPCMP2   = 0;
  localparam int BIT_UNUSED2   = 1;
  localparam int BIT_ULP_WAKE  = 2;
  localparam int BIT_BUS_COLL  = 3;
  localparam int BIT_EE_DONE   = 4;
  localparam int BIT_CMP1      = 5;
  localparam int BIT_CMP2      = 6;
  localparam int BIT_OSC_FAIL  = 7;

  // Power control fields
  localparam int BIT_BOR_STAT  = 0;
  localparam int BIT_POR_STAT  = 1;
  localparam int BIT_SW_BOR_EN = 4;
  localparam int BIT_ULP_EN    = 5;

  // Core control fields
  localparam int BIT_PERIPH_EN = 0;
  localparam int BIT_GLOBAL_EN = 1;

  // Implemented-bit masks and reset values
  localparam logic [7:0] MASK_FLAGS_ONE  = 8'h0f;
  localparam logic [7:0] MASK_FLAGS_TWO  = 8'hfd;
  localparam logic [7:0] MASK_POWER      = 8'h33;
  localparam logic [7:0] MASK_CORE       = 8'h03;
  localparam logic [7:0] RESET_FLAGS     = 8'h00;
  localparam logic [7:0] RESET_POWER     = 8'h10;
  localparam logic [1:0] BOR_MODE_SW     = 2'h1;

  // Capture/compare unit modes
  typedef enum logic [1:0] {
    CC_OFF,
    CC_CAPTURE,
    CC_COMPARE,
    CC_PWM
  } capcmp_mode_e;

  // Raw event pulses from peripherals
  typedef struct packed {
    logic timerOneOverflow;
    logic timerTwoMatch;
    logic capcmpOneCapture;
    logic capcmpOneMatch;
    logic capcmpTwoCapture;
    logic capcmpTwoMatch;
    logic serialDone;
    logic serialStopIdle;
    logic oscFail;
    logic eepromWriteDone;
    logic busCollision;
    logic ultraLowWake;
  } events_s;

endpackage

/* logic/edge_sync.sv */
// Two-flop synchroniser with change detector for a pin-level input
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Pin side
  input  wire logic pinLevel,
  // Synchronous side
  output logic      level,
  output logic      changed
);

  localparam logic [1:0] SETTLE_DONE = 2'h3;

  logic       stageOne;
  logic       stageTwo;
  logic       stageThree;
  logic [1:0] settle;

  // Stages keep shifting through reset so they hold the pin level on release
  always_ff @(posedge clk_sys) begin
    stageOne   <= pinLevel;
    stageTwo   <= stageOne;
    stageThree <= stageTwo;
  end

  // A pin idling high would fake an edge after reset; a change in these cycles is lost
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      settle <= 2'h0;
    end else if (settle != SETTLE_DONE) begin
      settle <= settle + 2'h1;
    end
  end

  // Change seen only after both synchroniser stages
  assign level   = stageTwo;
  assign changed = (settle == SETTLE_DONE) && (stageTwo ^ stageThree);

endmodule
`default_nettype wire

/* logic/peripheral_irq_flags.sv */
// Peripheral request flags, enables, power-control status and AXI4-Lite slave
//
// Overview of operation
// - Flags set on their condition regardless of any enable bit.
// - Event flags stay set until software writes zero.
// - Serial flag also sets on stop seen while idle in multi-master.
// - First register bit 2 sets on unit-1 capture or compare; unused in PWM.
// - First register bit 1 sets on timer-2 period match.
// - First register bit 0 sets on 16-bit timer-1 overflow.
// - Second register bit 7 sets on oscillator fail with internal switchover.
// - Second register bits 6 and 5 set on comparator output change.
// - Second register bit 4 sets when an EEPROM write completes.
// - Second register bit 3 sets on I2C master bus collision.
// - Second register bit 2 sets on ultra low-power wake-up.
// - Second register bit 0 sets on unit-2 capture or compare; unused in PWM.
// - Second register bit 1 reads zero; all bits reset to zero.
// - Power bit 5 enables wake-up current sink, resets to zero.
// - Power bit 4 enables brown-out, resets one, acts only in mode 01.
// - Power bit 1 cleared by power-on reset; software sets it.
// - Power bit 0 cleared by brown-out reset; software sets it.
// - Power bits 7-6 and 3-2 read zero.
// - Request reaches core only with flag, enable, peripheral enable and global enable.
//
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module peripheral_irq_flags (
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  // Reset cause strobes from the reset generator
  input  wire logic                        powerOnReset,
  input  wire logic                        brownoutReset,
  // Configuration
  input  wire logic [1:0]                  brownout_config_mode,
  input  wire irq_flags_pkg::capcmp_mode_e capcmpOneMode,
  input  wire irq_flags_pkg::capcmp_mode_e capcmpTwoMode,
  input  wire logic                        serialMultiMaster,
  input  wire logic                        serialIdle,
  // Peripheral events, same clock
  input  wire irq_flags_pkg::events_s      events,
  // Comparator output pins
  input  wire logic                        comparator_one_output,
  input  wire logic                        comparator_two_output,
  // Core side
  output logic                             coreInterrupt,
  output logic                             ultra_low_wake_enable,
  output logic                             brownoutDetectEnable,
  // AXI4-Lite write address
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [7:0]                  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  // AXI4-Lite write response
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  output logic [1:0]                       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  input  wire logic [7:0]                  s_axi_araddr,
  // AXI4-Lite read data
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp
);

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic knownOffset(input logic [7:0] addr);
    knownOffset = (addr == irq_flags_pkg::OFF_FLAGS_ONE)  ||
                  (addr == irq_flags_pkg::OFF_FLAGS_TWO)  ||
                  (addr == irq_flags_pkg::OFF_ENABLE_ONE) ||
                  (addr == irq_flags_pkg::OFF_ENABLE_TWO) ||
                  (addr == irq_flags_pkg::OFF_POWER_CTRL) ||
                  (addr == irq_flags_pkg::OFF_CORE_CTRL);
  endfunction

  // Pulse-width and off modes never set a capture/compare flag
  function automatic logic capcmpHit(input irq_flags_pkg::capcmp_mode_e mode,
                                     input logic                        capture,
                                     input logic                        match);
    capcmpHit = ((mode == irq_flags_pkg::CC_CAPTURE) && capture) ||
                ((mode == irq_flags_pkg::CC_COMPARE) && match);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] flagsOne;
  logic [7:0] flagsTwo;
  logic [7:0] enableOne;
  logic [7:0] enableTwo;
  logic [7:0] powerCtrl;
  logic [7:0] coreCtrl;

  ////////////////////////////////////////////////////////////////////////////
  // Comparator change detection

  logic cmpOneChanged;
  logic cmpTwoChanged;

  edge_sync u_cmp_one (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .pinLevel (comparator_one_output),
    .level    (),
    .changed  (cmpOneChanged)
  );

  edge_sync u_cmp_two (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .pinLevel (comparator_two_output),
    .level    (),
    .changed  (cmpTwoChanged)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Event qualification

  wire capOneHit = capcmpHit(capcmpOneMode, events.capcmpOneCapture,
                             events.capcmpOneMatch);
  wire capTwoHit = capcmpHit(capcmpTwoMode, events.capcmpTwoCapture,
                             events.capcmpTwoMatch);
  wire serialHit = events.serialDone ||
                   (events.serialStopIdle && serialMultiMaster && serialIdle);

  logic [7:0] setOne;
  logic [7:0] setTwo;

  always_comb begin
    setOne = 8'h00;
    setOne[irq_flags_pkg::BIT_TIMER_ONE_COUNT_OVF] = events.timerOneOverflow;
    setOne[irq_flags_pkg::BIT_TMR2_MAT] = events.timerTwoMatch;
    setOne[irq_flags_pkg::BIT_CAPCMP1]  = capOneHit;
    setOne[irq_flags_pkg::BIT_SERIAL]   = serialHit;
    setTwo = 8'h00;
    setTwo[irq_flags_pkg::BIT_CAPCMP2]  = capTwoHit;
    setTwo[irq_flags_pkg::BIT_ULP_WAKE] = events.ultraLowWake;
    setTwo[irq_flags_pkg::BIT_BUS_COLL] = events.busCollision;
    setTwo[irq_flags_pkg::BIT_EE_DONE]  = events.eepromWriteDone;
    setTwo[irq_flags_pkg::BIT_CMP1]     = cmpOneChanged;
    setTwo[irq_flags_pkg::BIT_CMP2]     = cmpTwoChanged;
    setTwo[irq_flags_pkg::BIT_OSC_FAIL] = events.oscFail;
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path

  logic       awHeld;
  logic       wHeld;
  logic [7:0] awAddr;
  logic [7:0] wByte;
  logic       wStrb0;

  // The live strobe is gone once the data beat is taken; use the latched one
  wire wrFire    = awHeld && wHeld && !s_axi_bvalid;
  wire wrLaneOk  = wStrb0;
  wire wrKnown   = knownOffset(awAddr);
  wire wrFlags1  = wrFire && (awAddr == irq_flags_pkg::OFF_FLAGS_ONE) && wrLaneOk;
  wire wrFlags2  = wrFire && (awAddr == irq_flags_pkg::OFF_FLAGS_TWO) && wrLaneOk;
  wire wrEnable1 = wrFire && (awAddr == irq_flags_pkg::OFF_ENABLE_ONE) && wrLaneOk;
  wire wrEnable2 = wrFire && (awAddr == irq_flags_pkg::OFF_ENABLE_TWO) && wrLaneOk;
  wire wrPower   = wrFire && (awAddr == irq_flags_pkg::OFF_POWER_CTRL) && wrLaneOk;
  wire wrCore    = wrFire && (awAddr == irq_flags_pkg::OFF_CORE_CTRL) && wrLaneOk;

  assign s_axi_awready = !awHeld;
  assign s_axi_wready  = !wHeld;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      awAddr <= 8'h00;
      wByte  <= 8'h00;
    end else begin
      if (s_axi_awvalid && !awHeld) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (wrFire) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && !wHeld) begin
        wHeld <= 1'b1;
        wByte <= s_axi_wdata[7:0];
      end else if (wrFire) begin
        wHeld <= 1'b0;
      end
    end
  end

  // Lane 0 strobe is latched with the data
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wStrb0 <= 1'b0;
    end else if (s_axi_wvalid && !wHeld) begin
      wStrb0 <= s_axi_wstrb[0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrKnown ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag and control registers

  // Software may only clear or set; a hardware set always wins the cycle
  wire [7:0] next_flagsOne = (((wrFlags1 && wStrb0) ? wByte : flagsOne) | setOne)
                             & irq_flags_pkg::MASK_FLAGS_ONE;
  wire [7:0] next_flagsTwo = (((wrFlags2 && wStrb0) ? wByte : flagsTwo) | setTwo)
                             & irq_flags_pkg::MASK_FLAGS_TWO;

  // Reset strobes clear status after any software write in the same cycle
  logic [7:0] next_power;
  always_comb begin
    next_power = (wrPower && wStrb0) ? (wByte & irq_flags_pkg::MASK_POWER) : powerCtrl;
    if (powerOnReset) begin
      next_power[irq_flags_pkg::BIT_POR_STAT] = 1'b0;
    end
    if (brownoutReset) begin
      next_power[irq_flags_pkg::BIT_BOR_STAT] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flagsOne  <= irq_flags_pkg::RESET_FLAGS;
      flagsTwo  <= irq_flags_pkg::RESET_FLAGS;
      enableOne <= 8'h00;
      enableTwo <= 8'h00;
      powerCtrl <= irq_flags_pkg::RESET_POWER;
      coreCtrl  <= 8'h00;
    end else begin
      flagsOne  <= next_flagsOne;
      flagsTwo  <= next_flagsTwo;
      powerCtrl <= next_power;
      if (wrEnable1 && wStrb0) begin
        enableOne <= wByte & irq_flags_pkg::MASK_FLAGS_ONE;
      end
      if (wrEnable2 && wStrb0) begin
        enableTwo <= wByte & irq_flags_pkg::MASK_FLAGS_TWO;
      end
      if (wrCore && wStrb0) begin
        coreCtrl <= wByte & irq_flags_pkg::MASK_CORE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core-facing outputs

  wire anyPending = |(flagsOne & enableOne) || |(flagsTwo & enableTwo);
  wire next_coreInterrupt = anyPending && coreCtrl[irq_flags_pkg::BIT_PERIPH_EN]
                            && coreCtrl[irq_flags_pkg::BIT_GLOBAL_EN];
  wire next_bodEnable = (brownout_config_mode == irq_flags_pkg::BOR_MODE_SW)
                        && powerCtrl[irq_flags_pkg::BIT_SW_BOR_EN];

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      coreInterrupt         <= 1'b0;
      ultra_low_wake_enable <= 1'b0;
      brownoutDetectEnable  <= 1'b0;
    end else begin
      coreInterrupt         <= next_coreInterrupt;
      ultra_low_wake_enable <= powerCtrl[irq_flags_pkg::BIT_ULP_EN];
      brownoutDetectEnable  <= next_bodEnable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path

  logic [7:0] readMux;
  always_comb begin
    unique case (s_axi_araddr)
      irq_flags_pkg::OFF_FLAGS_ONE:  readMux = flagsOne;
      irq_flags_pkg::OFF_FLAGS_TWO:  readMux = flagsTwo;
      irq_flags_pkg::OFF_ENABLE_ONE: readMux = enableOne;
      irq_flags_pkg::OFF_ENABLE_TWO: readMux = enableTwo;
      irq_flags_pkg::OFF_POWER_CTRL: readMux = powerCtrl;
      irq_flags_pkg::OFF_CORE_CTRL:  readMux = coreCtrl;
      default:                       readMux = 8'h00;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, readMux};
      s_axi_rresp  <= knownOffset(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* sim/irq_flags_chk.sv */
// Bus protocol and register checks for the request-flag block
`timescale 1ns/1ps
`default_nettype none
module irq_flags_chk (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // Brown-out control
  input wire logic [1:0]  brownout_config_mode,
  input wire logic        brownoutDetectEnable,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  logic [7:0] lastAddr;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////
  // Read data only tells its register through the taken address
  always_ff @(posedge clk_sys) begin
    if (!rst_n)
      lastAddr <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready)
      lastAddr <= s_axi_araddr;
  end
  //////////////////////////////////////////////////////////////////////////
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read data missing");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
  read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  flag_gap_a: assert property (
    s_axi_rvalid && lastAddr == irq_flags_pkg::OFF_FLAGS_TWO |-> !s_axi_rdata[1])
    else $error("unimplemented flag bit set");
  power_gaps_a: assert property (
    s_axi_rvalid && lastAddr == irq_flags_pkg::OFF_POWER_CTRL
    |-> s_axi_rdata[7:6] == 2'h0 && s_axi_rdata[3:2] == 2'h0)
    else $error("unimplemented power bits set");
  bor_gate_a: assert property (
    brownoutDetectEnable |-> $past(brownout_config_mode) == irq_flags_pkg::BOR_MODE_SW)
    else $error("brown-out enabled outside software mode");
endmodule
bind peripheral_irq_flags irq_flags_chk u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .brownout_config_mode(brownout_config_mode),
  .brownoutDetectEnable(brownoutDetectEnable), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata)
);
`default_nettype wire

/* sim/tb_peripheral_irq_flags.sv */
// Self-checking bench for the request-flag and power-control block
`timescale 1ns/1ps
`default_nettype none
module tb_peripheral_irq_flags;
  localparam logic [7:0] MK [6] = '{8'h0f, 8'hfd, 8'h0f, 8'hfd, 8'h33, 8'h03};
  logic                        clk_sys, rst_n, powerOnReset, brownoutReset;
  logic [1:0]                  brownout_config_mode;
  irq_flags_pkg::capcmp_mode_e capcmpOneMode, capcmpTwoMode;
  logic                        serialMultiMaster, serialIdle;
  irq_flags_pkg::events_s      events;
  logic                        comparator_one_output, comparator_two_output;
  logic                        coreInterrupt, ultra_low_wake_enable, brownoutDetectEnable;
  logic                        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                        s_axi_rvalid, s_axi_rready;
  logic [7:0]                  s_axi_awaddr, s_axi_araddr;
  logic [31:0]                 s_axi_wdata, s_axi_rdata;
  logic [3:0]                  s_axi_wstrb;
  logic [1:0]                  s_axi_bresp, s_axi_rresp;
  int                          mismatches = 0;
  int                          n_tests = 0;
  int                          m [6];
  logic [7:0]                  rs = 8'h18;
  logic [11:0]                 ev;

  peripheral_irq_flags uut (.*);

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic cc(input logic c, p, input irq_flags_pkg::capcmp_mode_e md);
    return (c && md == irq_flags_pkg::CC_CAPTURE) || (p && md == irq_flags_pkg::CC_COMPARE);
  endfunction
  task automatic chk(input logic [7:0] g, input int e);
    n_tests++;
    if (g !== 8'(e)) begin
      mismatches++;
      $display("[FAIL] %0t value %h expected %h", $time, g, 8'(e));
    end
  endtask
  task automatic chb(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t output %b expected %b", $time, g, e);
    end
  endtask
  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !rs[6];
    while (!(aw && w)) begin
      @(posedge clk_sys);
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    // Optional stall on bready exercises the held-response path
    forever begin
      @(posedge clk_sys);
      if (s_axi_bvalid && s_axi_bready)
        break;
      if (s_axi_bvalid)
        s_axi_bready <= 1'b1;
    end
    chk(8'(s_axi_bresp), a < 8'h18 ? 0 : 2);
    if (a < 8'h18)
      m[a[4:2]] = d & MK[a[4:2]];
    @(posedge clk_sys);
  endtask
  // Optional stall on rready exercises the held-data path
  task automatic rd(input logic [7:0] a, input logic st);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !st;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    forever begin
      @(posedge clk_sys);
      if (s_axi_rvalid && s_axi_rready)
        break;
      s_axi_rready <= 1'b1;
    end
    chk(s_axi_rdata[7:0], a < 8'h18 ? m[a[4:2]] : 0);
    chk(8'(s_axi_rresp), a < 8'h18 ? 0 : 2);
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic fire(input logic [11:0] x);
    irq_flags_pkg::events_s e;
    e = x;
    events <= e;
    @(posedge clk_sys);
    events <= '0;
    @(posedge clk_sys);
    m[0] |= {e.serialDone | (e.serialStopIdle & serialMultiMaster & serialIdle),
             cc(e.capcmpOneCapture, e.capcmpOneMatch, capcmpOneMode),
             e.timerTwoMatch, e.timerOneOverflow};
    m[1] |= {e.oscFail, 2'b0, e.eepromWriteDone, e.busCollision,
             e.ultraLowWake, 1'b0,
             cc(e.capcmpTwoCapture, e.capcmpTwoMatch, capcmpTwoMode)};
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    {powerOnReset, brownoutReset, serialMultiMaster, serialIdle} = '0;
    {comparator_one_output, comparator_two_output, brownout_config_mode} = '0;
    capcmpOneMode = irq_flags_pkg::CC_OFF;
    capcmpTwoMode = irq_flags_pkg::CC_OFF;
    events = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'h1;
    s_axi_bready = 1'b1;
    m = '{0, 0, 0, 0, 8'h10, 0};
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 7; i++) rd(8'(i * 4), i[0]);
    chb(ultra_low_wake_enable, 1'b0);
    for (int d = 0; d < 2; d++) begin
      for (int i = 0; i < 6; i++) wr(8'(i * 4), d ? 8'h00 : 8'hff);
      repeat (2) @(posedge clk_sys);
      chb(coreInterrupt, d == 0);
      for (int i = 0; i < 6; i++) rd(8'(i * 4), d[0]);
    end
    // Power control: enables, gating by mode, reset-cause strobes
    wr(8'h10, 8'h3f);
    for (int i = 0; i < 4; i++) begin
      brownout_config_mode <= 2'(i);
      repeat (3) @(posedge clk_sys);
      chb(brownoutDetectEnable, i == 1);
    end
    chb(ultra_low_wake_enable, 1'b1);
    powerOnReset <= 1'b1;
    @(posedge clk_sys);
    powerOnReset <= 1'b0;
    brownoutReset <= 1'b1;
    @(posedge clk_sys);
    brownoutReset <= 1'b0;
    m[4] = 8'h30;
    rd(8'h10, 1'b1);
    wr(8'h10, 8'h03);
    rd(8'h10, 1'b0);
    // Random events under random modes, enables all off
    for (int i = 0; i < 40; i++) begin
      rs = nx(rs);
      capcmpOneMode <= irq_flags_pkg::capcmp_mode_e'(rs[1:0]);
      capcmpTwoMode <= irq_flags_pkg::capcmp_mode_e'(rs[3:2]);
      {serialMultiMaster, serialIdle} <= rs[5:4];
      @(posedge clk_sys);
      ev = {rs[7:4], nx(rs)};
      rs = nx(rs);
      fire(ev);
      rd(8'h00, rs[1]);
      rd(8'h04, rs[2]);
      if (rs[0]) begin
        wr(8'h00, 8'h00);
        wr(8'h04, 8'h00);
      end
    end
    // Overflow pulse lands in the very cycle the clearing write does
    fork
      wr(8'h00, 8'h00);
      begin
        @(posedge clk_sys);
        events <= irq_flags_pkg::events_s'(12'h800);
        @(posedge clk_sys);
        events <= '0;
      end
    join
    m[0] = 1;
    rd(8'h00, 1'b0);
    wr(8'h04, 8'h00);
    comparator_two_output <= 1'b1;
    repeat (5) @(posedge clk_sys);
    m[1] |= 8'h40;
    rd(8'h04, 1'b0);
    comparator_one_output <= 1'b1;
    repeat (5) @(posedge clk_sys);
    m[1] |= 8'h20;
    rd(8'h04, 1'b1);
    wr(8'h00, 8'h00);
    fire(12'h800);
    for (int i = 0; i < 3; i++) begin
      wr(8'h08, 8'(i < 2));
      wr(8'h14, i ? 8'h03 : 8'h02);
      repeat (3) @(posedge clk_sys);
      chb(coreInterrupt, i == 1);
    end
    wr(8'h18, 8'h5a);
    rd(8'h18, 1'b0);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire
